// *** core/io_port_pkg.sv ***
package io_port_pkg;

    // Clocking
    localparam int CORE_CLK_HZ     = 10_000_000;
    localparam int REF_CLK_HZ      = 100_000_000;
    localparam int REF_TICK_RAW    = CORE_CLK_HZ / REF_CLK_HZ;
    localparam int REF_TICK_CYCLES = (REF_TICK_RAW < 1) ? 1 : REF_TICK_RAW;

    // Clock blocks
    localparam int         CLOCK_BLOCKS  = 6;
    localparam int         CB_IDX_W      = 3;
    localparam int         CB_DIV_W      = 8;
    localparam logic [2:0] CLK_SEL_RESET = 3'h0;

    // Port counter and transfer register
    localparam int          COUNT_W     = 16;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam int          XFER_W      = 32;
    localparam logic [31:0] XFER_RESET  = 32'h0000_0000;
    localparam int          SHIFT_CNT_W = 6;

    // Conditional sampling modes
    typedef enum logic [1:0] {
        COND_NONE,
        COND_EQUAL,
        COND_DIFFER
    } cond_mode_t;

    typedef enum logic {
        OUT_IDLE,
        OUT_SHIFT
    } out_state_t;

    typedef enum logic {
        IN_ARMED,
        IN_SHIFT
    } in_state_t;

endpackage

// *** core/io_sync.sv ***
`timescale 1ns/1ps
module io_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // io_sync

// *** core/clock_block_set.sv ***
`timescale 1ns/1ps
module clock_block_set
    import io_port_pkg::*;
(
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic                                ce,
    // Sources and setup
    input  wire logic                                src_pin,
    input  wire logic [CLOCK_BLOCKS-2:0]             use_pin,
    input  wire logic [(CLOCK_BLOCKS-1)*CB_DIV_W-1:0] divide,
    // Ticks
    output logic      [CLOCK_BLOCKS-1:0]             tick
);
    logic [15:0]         ref_cnt;
    logic                pin_prev;
    logic [CB_DIV_W-1:0] div_cnt [CLOCK_BLOCKS-1];

    wire ref_tick = (ref_cnt == 16'(REF_TICK_CYCLES - 1));
    wire pin_rise = src_pin & ~pin_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt  <= 16'h0000;
            pin_prev <= 1'b0;
        end else if (ce) begin
            ref_cnt  <= ref_tick ? 16'h0000 : 16'(ref_cnt + 16'h0001);
            pin_prev <= src_pin;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick[0] <= 1'b0;
            for (int i = 0; i < CLOCK_BLOCKS - 1; i++) begin
                div_cnt[i]  <= '0;
                tick[i + 1] <= 1'b0;
            end
        end else if (ce) begin
            tick[0] <= ref_tick;
            for (int i = 0; i < CLOCK_BLOCKS - 1; i++) begin
                tick[i + 1] <= 1'b0;
                if (use_pin[i] ? pin_rise : ref_tick) begin
                    if (div_cnt[i] >= divide[i*CB_DIV_W +: CB_DIV_W]) begin
                        div_cnt[i]  <= '0;
                        tick[i + 1] <= 1'b1;
                    end else begin
                        div_cnt[i] <= CB_DIV_W'(div_cnt[i] + 1'b1);
                    end
                end
            end
        end
    end
endmodule // clock_block_set

// *** core/timed_io_port.sv ***
// Behaviour
// - Port widths one, four, eight, sixteen, thirty-two
// - All pins of a port share direction
// - Drive pins or sample, optionally wait condition
// - Every processor access completes in one cycle
// - Open collector: zero pulls low, one floats
// - Data passes serialiser and transfer register
// - Sixteen-bit counter times pin transfers
// - Counter readable; transfers deferrable to time
// - Each transfer captures counter as timestamp
// - Enabled link disables port on shared pins
// - Enabled narrower port overrules wider port
// - Unshared pins stay with the wider port
// - Transfers always use full nominal width
// - Six clock blocks, block 0 reference
// - Clock block may use divided pin clock
// - Strobe in qualifies input, strobe out accompanies
// - Reset attaches port to clock block 0
// - Pin events signalled straight to tile
// - Pull-downs enabled while held in reset
`timescale 1ns/1ps
module timed_io_port #(
    parameter int PORT_WIDTH = 4
) (
    // Clock and reset
    input  wire logic                                           CORE_CLK,
    input  wire logic                                           RST,
    input  wire logic                                           CE,
    // Port setup
    input  wire logic                                           PORT_ENABLE,
    input  wire logic                                           DIR_OUT,
    input  wire logic                                           OPEN_COLLECTOR,
    input  wire logic                                           STROBED,
    input  wire logic                                           LINK_ENABLE,
    input  wire logic [PORT_WIDTH-1:0]                          NARROW_CLAIM,
    input  wire io_port_pkg::cond_mode_t                        COND_MODE,
    input  wire logic [PORT_WIDTH-1:0]                          COND_VALUE,
    // Clock block setup
    input  wire logic                                           CLK_SEL_WR,
    input  wire logic [io_port_pkg::CB_IDX_W-1:0]               CLK_SEL,
    input  wire logic [io_port_pkg::CLOCK_BLOCKS-2:0]           CB_USE_PIN,
    input  wire logic [(io_port_pkg::CLOCK_BLOCKS-1)*io_port_pkg::CB_DIV_W-1:0] CB_DIVIDE,
    // Processor access
    input  wire logic                                           ACC_REQ,
    input  wire logic                                           ACC_WRITE,
    input  wire logic                                           ACC_TIMED,
    input  wire logic [io_port_pkg::COUNT_W-1:0]                ACC_TIME,
    input  wire logic [io_port_pkg::XFER_W-1:0]                 ACC_WDATA,
    output logic                                                ACC_ACK,
    output logic                                                ACC_OK,
    output logic      [io_port_pkg::XFER_W-1:0]                 ACC_RDATA,
    output logic      [io_port_pkg::COUNT_W-1:0]                COUNT,
    output logic      [io_port_pkg::COUNT_W-1:0]                TIMESTAMP,
    output logic                                                EVENT,
    output logic      [io_port_pkg::CB_IDX_W-1:0]               CLK_SEL_NOW,
    // Pins
    input  wire logic [PORT_WIDTH-1:0]                          PIN_IN,
    input  wire logic                                           CLK_PIN,
    input  wire logic                                           STROBE_IN,
    output logic      [PORT_WIDTH-1:0]                          PIN_OUT,
    output logic      [PORT_WIDTH-1:0]                          PIN_OE,
    output logic      [PORT_WIDTH-1:0]                          PIN_PULLDOWN,
    output logic                                                STROBE_OUT
);
    import io_port_pkg::*;

    localparam int SHIFTS = XFER_W / PORT_WIDTH;

    function automatic logic time_hit(input logic [COUNT_W-1:0] now,
                                      input logic [COUNT_W-1:0] target);
        time_hit = (now == target);
    endfunction

    // Synchronised pins
    logic [PORT_WIDTH-1:0]   pin_s;
    logic                    strobe_s;
    logic                    clkpin_s;
    logic [CLOCK_BLOCKS-1:0] block_tick;

    io_sync #(
        .WIDTH (PORT_WIDTH + 2)
    ) u_sync (
        .clk (CORE_CLK),
        .rst (RST),
        .ce  (CE),
        .d   ({CLK_PIN, STROBE_IN, PIN_IN}),
        .q   ({clkpin_s, strobe_s, pin_s})
    );

    clock_block_set u_blocks (
        .clk     (CORE_CLK),
        .rst     (RST),
        .ce      (CE),
        .src_pin (clkpin_s),
        .use_pin (CB_USE_PIN),
        .divide  (CB_DIVIDE),
        .tick    (block_tick)
    );

    // Internal state
    out_state_t            out_state;
    in_state_t             in_state;
    logic [XFER_W-1:0]     xfer;
    logic                  xfer_full;
    logic                  xfer_timed;
    logic [COUNT_W-1:0]    xfer_time;
    logic                  in_timed;
    logic [COUNT_W-1:0]    in_time;
    logic [XFER_W-1:0]     shift;
    logic [SHIFT_CNT_W-1:0] shift_cnt;
    logic [PORT_WIDTH-1:0] drive_data;

    // Clock selection and pin ownership
    wire                  ce_tick = CE & block_tick[CLK_SEL_NOW];
    wire [PORT_WIDTH-1:0] owned   = {PORT_WIDTH{PORT_ENABLE & ~LINK_ENABLE}}
                                    & ~NARROW_CLAIM;
    wire [PORT_WIDTH-1:0] pin_val = pin_s & owned;

    // Sampling qualifiers
    wire cond_ok   = (COND_MODE == COND_NONE)
                   | ((COND_MODE == COND_EQUAL) & (pin_val == COND_VALUE))
                   | ((COND_MODE == COND_DIFFER) & (pin_val != COND_VALUE));
    wire strobe_ok = ~STROBED | strobe_s;
    wire in_time_ok = ~in_timed | time_hit(COUNT, in_time);
    wire sample_now = ce_tick & ~DIR_OUT & PORT_ENABLE & strobe_ok
                    & ((in_state == IN_SHIFT) | (cond_ok & in_time_ok));
    wire [XFER_W-1:0] in_shift_nxt = (shift >> PORT_WIDTH)
                    | (XFER_W'(pin_val) << (XFER_W - PORT_WIDTH));
    wire [SHIFT_CNT_W-1:0] cnt_inc = SHIFT_CNT_W'(shift_cnt + 1'b1);
    wire in_done = sample_now & (cnt_inc == SHIFT_CNT_W'(SHIFTS));

    // Output load and shift
    wire out_load  = ce_tick & DIR_OUT & (out_state == OUT_IDLE) & xfer_full
                   & (~xfer_timed | time_hit(COUNT, xfer_time));
    wire out_drive = ce_tick & (out_state == OUT_SHIFT);
    wire out_last  = out_drive & (cnt_inc == SHIFT_CNT_W'(SHIFTS));

    // Processor access decode
    wire acc_wr_ok = ACC_REQ & ACC_WRITE & DIR_OUT & ~xfer_full;
    wire acc_rd_ok = ACC_REQ & ~ACC_WRITE & ~DIR_OUT & xfer_full;

    // Pin drive, new chunk leaves with its strobe
    wire [PORT_WIDTH-1:0] drive_nxt = out_drive ? shift[PORT_WIDTH-1:0] : drive_data;
    wire [PORT_WIDTH-1:0] next_oe   = {PORT_WIDTH{DIR_OUT}} & owned
                                    & (OPEN_COLLECTOR ? ~drive_nxt : {PORT_WIDTH{1'b1}});
    wire [PORT_WIDTH-1:0] next_out  = OPEN_COLLECTOR ? '0 : drive_nxt;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            CLK_SEL_NOW <= CLK_SEL_RESET;
        end else if (CE && CLK_SEL_WR) begin
            CLK_SEL_NOW <= (CLK_SEL < CB_IDX_W'(CLOCK_BLOCKS)) ? CLK_SEL : CLK_SEL_NOW;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            COUNT <= COUNT_RESET;
        end else if (ce_tick) begin
            COUNT <= COUNT_W'(COUNT + 1'b1);
        end
    end

    // Access answers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ACC_ACK   <= 1'b0;
            ACC_OK    <= 1'b0;
            ACC_RDATA <= XFER_RESET;
        end else if (CE) begin
            ACC_ACK <= ACC_REQ;
            ACC_OK  <= acc_wr_ok | acc_rd_ok;
            if (acc_rd_ok) begin
                ACC_RDATA <= xfer;
            end
        end
    end

    // Transfer register
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            xfer       <= XFER_RESET;
            xfer_full  <= 1'b0;
            xfer_timed <= 1'b0;
            xfer_time  <= COUNT_RESET;
        end else if (CE) begin
            if (acc_wr_ok) begin
                xfer       <= ACC_WDATA;
                xfer_full  <= 1'b1;
                xfer_timed <= ACC_TIMED;
                xfer_time  <= ACC_TIME;
            end
            if (acc_rd_ok || out_load) begin
                xfer_full <= 1'b0;
            end
            if (in_done) begin
                xfer      <= in_shift_nxt;
                xfer_full <= 1'b1;
            end
        end
    end

    // Deferred input time
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            in_timed <= 1'b0;
            in_time  <= COUNT_RESET;
        end else if (CE) begin
            if (in_done) begin
                in_timed <= 1'b0;
            end
            if (ACC_REQ && !ACC_WRITE && ACC_TIMED) begin
                in_timed <= 1'b1;
                in_time  <= ACC_TIME;
            end
        end
    end

    // Serialiser
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            shift      <= XFER_RESET;
            shift_cnt  <= '0;
            out_state  <= OUT_IDLE;
            in_state   <= IN_ARMED;
            drive_data <= '0;
        end else if (CE) begin
            if (out_load) begin
                shift     <= xfer;
                shift_cnt <= '0;
                out_state <= OUT_SHIFT;
            end else if (out_drive) begin
                drive_data <= shift[PORT_WIDTH-1:0];
                shift      <= shift >> PORT_WIDTH;
                shift_cnt  <= out_last ? '0 : cnt_inc;
                out_state  <= out_last ? OUT_IDLE : OUT_SHIFT;
            end else if (sample_now) begin
                shift     <= in_shift_nxt;
                shift_cnt <= in_done ? '0 : cnt_inc;
                in_state  <= in_done ? IN_ARMED : IN_SHIFT;
            end
        end
    end

    // Timestamp, event and strobe
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            TIMESTAMP  <= COUNT_RESET;
            EVENT      <= 1'b0;
            STROBE_OUT <= 1'b0;
        end else if (CE) begin
            if (out_load || in_done) begin
                TIMESTAMP <= COUNT;
            end
            EVENT <= in_done;
            if (ce_tick) begin
                STROBE_OUT <= out_drive;
            end
        end
    end

    // Pin outputs
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PIN_OUT      <= '0;
            PIN_OE       <= '0;
            PIN_PULLDOWN <= '1;
        end else if (CE) begin
            PIN_OUT      <= next_out;
            PIN_OE       <= next_oe;
            PIN_PULLDOWN <= ~owned;
        end
    end

    a_access_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && ACC_REQ |=> ACC_ACK)
        else $error("access not answered next cycle");

    a_counter_wrap: assert property (@(posedge CORE_CLK) disable iff (RST)
        ce_tick |=> COUNT == COUNT_W'($past(COUNT) + 1'b1))
        else $error("counter did not step or wrap");

    a_counter_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        !ce_tick |=> COUNT == $past(COUNT))
        else $error("counter moved without tick");

    a_link_release: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && LINK_ENABLE |=> PIN_OE == '0)
        else $error("pin driven while link enabled");

    a_narrow_wins: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE |=> (PIN_OE & $past(NARROW_CLAIM)) == '0)
        else $error("wider port drove claimed pin");

    a_open_drain: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && OPEN_COLLECTOR |=> PIN_OUT == '0 && (PIN_OE & $past(drive_nxt)) == '0)
        else $error("open collector drove a one");

    a_input_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && !DIR_OUT |=> PIN_OE == '0)
        else $error("input port drove pins");

    a_stamp_event: assert property (@(posedge CORE_CLK) disable iff (RST)
        EVENT |-> TIMESTAMP == $past(COUNT) && xfer_full)
        else $error("event without matching timestamp");

    a_strobe_tick: assert property (@(posedge CORE_CLK) disable iff (RST)
        ce_tick |=> STROBE_OUT == $past(out_drive))
        else $error("strobe out not tied to output");

    a_strobe_data: assert property (@(posedge CORE_CLK) disable iff (RST)
        out_drive && !OPEN_COLLECTOR |=> PIN_OUT == $past(shift[PORT_WIDTH-1:0]))
        else $error("output chunk not aligned with strobe");

    a_refuse_read: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && ACC_REQ && !ACC_WRITE && DIR_OUT |=> ACC_ACK && !ACC_OK)
        else $error("read accepted on output port");

    a_event_full: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && in_done |=> EVENT && xfer_full)
        else $error("captured word not signalled");

    a_pin_drive: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && DIR_OUT && !OPEN_COLLECTOR |=> PIN_OE == $past(owned))
        else $error("output port not driving owned pins");

    a_pulldown_own: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE |=> PIN_PULLDOWN == ~$past(owned))
        else $error("pull-down does not follow ownership");

    a_sel_range: assert property (@(posedge CORE_CLK) disable iff (RST)
        CE && CLK_SEL_WR && CLK_SEL >= CB_IDX_W'(CLOCK_BLOCKS) |=> $stable(CLK_SEL_NOW))
        else $error("out of range clock block selected");

endmodule // timed_io_port

// *** verification/pin_partner.sv ***
`timescale 1ns/1ps
module pin_partner #(
    parameter int W = 4
) (
    // Port side
    input  wire logic         clk,
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pin_pulldown,
    // Board side
    output logic      [W-1:0] pin_level,
    output logic              clk_pin,
    output logic              strobe_in
);
    logic [W-1:0] drive_val;
    logic         drive_on;

    initial begin
        drive_val = '0;
        drive_on = 1'h0;
        clk_pin = 1'h0;
        strobe_in = 1'h0;
    end

    // Port drive, else board drive, else pull-up unless pull-down on
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (drive_on) begin
                pin_level[i] = drive_val[i];
            end else begin
                pin_level[i] = ~pin_pulldown[i];
            end
        end
    end

    task set_pins(input logic [W-1:0] v);
        @(posedge clk);
        drive_val <= v;
        drive_on <= 1'h1;
    endtask

    task set_strobe(input logic v);
        @(posedge clk);
        strobe_in <= v;
    endtask

    // Clock pin stands still outside bursts
    task clk_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            clk_pin <= 1'h1;
            repeat (3) @(posedge clk);
            clk_pin <= 1'h0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule  // pin_partner

// *** verification/timed_io_port_tb.sv ***
`timescale 1ns/1ps
module timed_io_port_tb;
    import io_port_pkg::*;
    logic        core_clk = 1'h0;
    logic        rst = 1'h1;
    logic        ce = 1'h1;
    logic        port_enable = 1'h1;
    logic        dir_out = 1'h1;
    logic        open_collector = 1'h0;
    logic        strobed = 1'h0;
    logic        link_enable = 1'h0;
    logic [3:0]  narrow_claim = 4'h0;
    cond_mode_t  cond_mode = COND_NONE;
    logic [3:0]  cond_value = 4'h6;
    logic        clk_sel_wr = 1'h0;
    logic [2:0]  clk_sel = 3'h0;
    logic [4:0]  cb_use_pin = 5'h01;
    logic [39:0] cb_divide = 40'h01;
    logic        acc_req = 1'h0;
    logic        acc_write = 1'h0;
    logic        acc_timed = 1'h0;
    logic [15:0] acc_time = 16'h0;
    logic [31:0] acc_wdata = 32'h0;
    logic        acc_ack, acc_ok, port_event, strobe_out, clk_pin, strobe_in;
    logic [31:0] acc_rdata;
    logic [15:0] count, timestamp;
    logic [2:0]  clk_sel_now;
    logic [3:0]  pin_level, pin_out, pin_oe, pin_pulldown;
    int          n_mismatch = 0;
    int          n_checks = 0;

    always #50 core_clk = ~core_clk;

    timed_io_port #(
        .PORT_WIDTH(4)
    ) i_timed_io_port (
        .CORE_CLK(core_clk), .RST(rst), .CE(ce), .PORT_ENABLE(port_enable),
        .DIR_OUT(dir_out), .OPEN_COLLECTOR(open_collector), .STROBED(strobed),
        .LINK_ENABLE(link_enable), .NARROW_CLAIM(narrow_claim), .COND_MODE(cond_mode),
        .COND_VALUE(cond_value), .CLK_SEL_WR(clk_sel_wr), .CLK_SEL(clk_sel),
        .CB_USE_PIN(cb_use_pin), .CB_DIVIDE(cb_divide), .ACC_REQ(acc_req),
        .ACC_WRITE(acc_write), .ACC_TIMED(acc_timed), .ACC_TIME(acc_time),
        .ACC_WDATA(acc_wdata), .ACC_ACK(acc_ack), .ACC_OK(acc_ok), .ACC_RDATA(acc_rdata),
        .COUNT(count), .TIMESTAMP(timestamp), .EVENT(port_event),
        .CLK_SEL_NOW(clk_sel_now), .PIN_IN(pin_level), .CLK_PIN(clk_pin),
        .STROBE_IN(strobe_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_PULLDOWN(pin_pulldown), .STROBE_OUT(strobe_out)
    );

    pin_partner #(
        .W(4)
    ) i_pin_partner (
        .clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pulldown),
        .pin_level(pin_level), .clk_pin(clk_pin), .strobe_in(strobe_in)
    );

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One processor access, answer one cycle later
    task acc(input logic wr, input logic tm, input logic [15:0] t, input logic [31:0] d,
             output logic ok, output logic [31:0] rd);
        @(posedge core_clk);
        acc_req <= 1'h1;
        acc_write <= wr;
        acc_timed <= tm;
        acc_time <= t;
        acc_wdata <= d;
        @(posedge core_clk);
        acc_req <= 1'h0;
        #1 chk(acc_ack, 1'h1);
        ok = acc_ok;
        rd = acc_rdata;
    endtask

    task sel(input logic [2:0] b, input logic [2:0] exp);
        @(posedge core_clk);
        clk_sel_wr <= 1'h1;
        clk_sel <= b;
        @(posedge core_clk);
        clk_sel_wr <= 1'h0;
        #1 chk(clk_sel_now, exp);
    endtask

    // Line level per chunk, LSB chunk first
    task get_word(input logic [31:0] d, input logic [3:0] own, input logic oc);
        int n;
        logic [3:0] c;
        n = 0;
        while (strobe_out !== 1'h1 && n < 60) begin
            @(posedge core_clk);
            #1 n++;
        end
        for (int k = 0; k < 8; k++) begin
            c = d[k*4 +: 4];
            chk(strobe_out, 1'h1);
            chk(pin_level, c & own);
            chk(pin_oe, oc ? ~c & own : own);
            @(posedge core_clk);
            #1;
        end
    endtask

    task no_event(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1 chk(port_event, 1'h0);
        end
    endtask

    task read_word(input logic [31:0] exp);
        int n;
        logic ok;
        logic [31:0] rd;
        n = 0;
        while (port_event !== 1'h1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(port_event, 1'h1);
        acc(1'h0, 1'h0, 16'h0, 32'h0, ok, rd);
        chk(ok, 1'h1);
        chk(rd, exp);
    endtask

    task t_count();
        logic [15:0] c;
        c = count;
        repeat (5) @(posedge core_clk);
        #1 chk(count, c + 16'h5);
        chk(pin_pulldown, 4'h0);
        @(posedge core_clk);
        ce <= 1'h0;
        #1 c = count;
        repeat (5) @(posedge core_clk);
        ce <= 1'h1;
        #1 chk(count, c);
    endtask

    task t_clk();
        logic [15:0] c;
        sel(3'h1, 3'h1);
        repeat (2) @(posedge core_clk);
        #1 c = count;
        repeat (10) @(posedge core_clk);
        #1 chk(count, c);
        i_pin_partner.clk_pulses(6);
        repeat (4) @(posedge core_clk);
        #1 chk(count, c + 16'h3);
        sel(3'h6, 3'h1);
        sel(3'h5, 3'h5);
        repeat (2) @(posedge core_clk);
        #1 c = count;
        repeat (4) @(posedge core_clk);
        #1 chk(count, c + 16'h4);
        @(posedge core_clk);
        rst <= 1'h1;
        @(posedge core_clk);
        rst <= 1'h0;
        #1 chk(clk_sel_now, 3'h0);
    endtask

    task t_write();
        logic ok;
        logic [31:0] rd;
        sel(3'h1, 3'h1);
        acc(1'h1, 1'h0, 16'h0, 32'h8765_4321, ok, rd);
        chk(ok, 1'h1);
        acc(1'h1, 1'h0, 16'h0, 32'h1111_1111, ok, rd);
        chk(ok, 1'h0);
        acc(1'h0, 1'h0, 16'h0, 32'h0, ok, rd);
        chk(ok, 1'h0);
        sel(3'h0, 3'h0);
        get_word(32'h8765_4321, 4'hF, 1'h0);
        @(posedge core_clk);
        open_collector <= 1'h1;
        acc(1'h1, 1'h0, 16'h0, 32'h0F0F_33C5, ok, rd);
        get_word(32'h0F0F_33C5, 4'hF, 1'h1);
        @(posedge core_clk);
        open_collector <= 1'h0;
        narrow_claim <= 4'h3;
        acc(1'h1, 1'h0, 16'h0, 32'hA5A5_5A5A, ok, rd);
        chk(pin_pulldown, 4'h3);
        get_word(32'hA5A5_5A5A, 4'hC, 1'h0);
        @(posedge core_clk);
        narrow_claim <= 4'h0;
        link_enable <= 1'h1;
        acc(1'h1, 1'h0, 16'h0, 32'hFFFF_FFFF, ok, rd);
        repeat (4) @(posedge core_clk);
        #1 chk(pin_oe, 4'h0);
        chk(pin_pulldown, 4'hF);
        repeat (12) @(posedge core_clk);
        link_enable <= 1'h0;
    endtask

    task t_timed();
        logic ok;
        logic [31:0] rd;
        logic [15:0] t;
        #1 t = count + 16'h1E;
        acc(1'h1, 1'h1, t, 32'hC3C3_3C3C, ok, rd);
        repeat (20) begin
            @(posedge core_clk);
            #1 chk(strobe_out, 1'h0);
        end
        get_word(32'hC3C3_3C3C, 4'hF, 1'h0);
        chk(timestamp, t);
    endtask

    task t_input();
        logic ok;
        logic [31:0] rd;
        logic [3:0] v;
        @(posedge core_clk);
        dir_out <= 1'h0;
        for (int m = 1; m < 3; m++) begin
            v = (m == 1) ? 4'h6 : 4'h9;
            i_pin_partner.set_pins(~v);
            cond_mode <= cond_mode_t'(m);
            repeat (12) @(posedge core_clk);
            acc(1'h0, 1'h0, 16'h0, 32'h0, ok, rd);
            acc(1'h0, 1'h0, 16'h0, 32'h0, ok, rd);
            chk(ok, 1'h0);
            no_event(12);
            i_pin_partner.set_pins(v);
            read_word({8{v}});
        end
        @(posedge core_clk);
        cond_mode <= COND_NONE;
        strobed <= 1'h1;
        repeat (12) @(posedge core_clk);
        acc(1'h0, 1'h0, 16'h0, 32'h0, ok, rd);
        no_event(16);
        i_pin_partner.set_strobe(1'h1);
        read_word(32'h9999_9999);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        #1 chk(pin_pulldown, 4'hF);
        chk(clk_sel_now, 3'h0);
        chk(pin_oe, 4'h0);
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        #1 t_count();
        t_clk();
        t_write();
        t_timed();
        t_input();
        complete_run();
    end

    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
endmodule  // timed_io_port_tb
